// >>> pkg/wer_pkg.sv
// wake enable register bank: shared constants and types
package wer_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int WER_AXI_AW = 8;
  localparam int WER_AXI_DW = 32;
  localparam int WER_STRB_W = WER_AXI_DW / 8;
  localparam int WER_ADDR_LSB = 2;
  localparam int WER_IDX_W = WER_AXI_AW - WER_ADDR_LSB;
  localparam int WER_REG_W = 8;
  localparam int WER_LANE0 = 0;

  typedef logic [WER_REG_W-1:0] wer_byte_t;
  typedef logic [WER_IDX_W-1:0] wer_idx_t;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam wer_idx_t WER_IDX_EN3 = 6'h0c;
  localparam wer_idx_t WER_IDX_EN4 = 6'h0d;
  localparam wer_idx_t WER_IDX_STS3 = 6'h20;
  localparam wer_idx_t WER_IDX_STS4 = 6'h21;
  localparam wer_idx_t WER_IDX_CTRL = 6'h22;
  localparam wer_idx_t WER_IDX_INT_STS = 6'h24;
  localparam wer_idx_t WER_IDX_INT_CLR = 6'h25;
  localparam wer_idx_t WER_IDX_INT_EN = 6'h26;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam wer_byte_t WER_EN_RST = 8'h00;
  localparam wer_byte_t WER_STS_RST = 8'h00;
  localparam logic WER_CTRL_RST = 1'b0;
  localparam int WER_CTRL_GLOBAL_BIT = 0;
  localparam int WER_EN3_SMI_BIT = 3;

  localparam int WER_INT_W = 3;
  localparam int WER_INT_STS3 = 0;
  localparam int WER_INT_STS4 = 1;
  localparam int WER_INT_WAKE = 2;
  localparam logic [WER_INT_W-1:0] WER_INT_RST = 3'h0;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] WER_RESP_OKAY = 2'h0;
  localparam logic [1:0] WER_RESP_SLVERR = 2'h2;

endpackage

// >>> hdl/wer_sticky.sv
// sticky flag bank: hardware set wins over software clear
`timescale 1ns/1ps
module wer_sticky #(
  parameter int W = 8
) (
  input wire logic clock, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [W-1:0] set, // set per bit
  input wire logic [W-1:0] clr, // clear per bit
  output logic [W-1:0] q // flags
);
  import wer_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (W < 1) begin : g_bad_w
    $error("wer_sticky needs W of at least one");
  end

  logic [W-1:0] q_d;

  always_comb begin
    q_d = (q & ~clr) | set;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= q_d;
    end
  end

endmodule

// >>> hdl/wer_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module wer_axil_slave (
  input wire logic clock, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [wer_pkg::WER_AXI_AW-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [wer_pkg::WER_AXI_DW-1:0] s_wdata, // write data
  input wire logic [wer_pkg::WER_STRB_W-1:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [wer_pkg::WER_AXI_AW-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [wer_pkg::WER_AXI_DW-1:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  output logic wr_en, // register write pulse
  output logic [wer_pkg::WER_IDX_W-1:0] wr_idx, // register index to write
  output logic [wer_pkg::WER_AXI_DW-1:0] wr_data, // data to write
  output logic [wer_pkg::WER_STRB_W-1:0] wr_strb, // byte enables
  input wire logic wr_err, // index not writable
  output logic rd_en, // register read pulse
  output logic [wer_pkg::WER_IDX_W-1:0] rd_idx, // register index to read
  input wire logic [wer_pkg::WER_AXI_DW-1:0] rd_data, // read value
  input wire logic rd_err // index not readable
);
  import wer_pkg::*;

  logic aw_full_q, aw_full_d, w_full_q, w_full_d, ar_full_q, ar_full_d;
  logic [WER_AXI_AW-1:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
  logic [WER_AXI_DW-1:0] wdata_q, wdata_d, rdata_d;
  logic [WER_STRB_W-1:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, arready_d, bvalid_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;

  assign wr_en = aw_full_q && w_full_q && !s_bvalid;
  assign rd_en = ar_full_q && !s_rvalid;
  assign wr_idx = awaddr_q[WER_AXI_AW-1:WER_ADDR_LSB];
  assign rd_idx = araddr_q[WER_AXI_AW-1:WER_ADDR_LSB];
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    ar_full_d = ar_full_q;
    awaddr_d = awaddr_q;
    araddr_d = araddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_bvalid;
    bresp_d = s_bresp;
    rvalid_d = s_rvalid;
    rresp_d = s_rresp;
    rdata_d = s_rdata;
    if (s_awvalid && s_awready) begin
      aw_full_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_full_d = 1'b1;
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (s_bvalid && s_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_en) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_err ? WER_RESP_SLVERR : WER_RESP_OKAY;
    end
    if (s_arvalid && s_arready) begin
      ar_full_d = 1'b1;
      araddr_d = s_araddr;
    end
    if (s_rvalid && s_rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_en) begin
      ar_full_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rd_data;
      rresp_d = rd_err ? WER_RESP_SLVERR : WER_RESP_OKAY;
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    arready_d = !ar_full_d && !rvalid_d;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      ar_full_q <= 1'b0;
      awaddr_q <= '0;
      araddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= WER_RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp <= WER_RESP_OKAY;
      s_rdata <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      ar_full_q <= ar_full_d;
      awaddr_q <= awaddr_d;
      araddr_q <= araddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_awready <= awready_d;
      s_wready <= wready_d;
      s_arready <= arready_d;
      s_bvalid <= bvalid_d;
      s_bresp <= bresp_d;
      s_rvalid <= rvalid_d;
      s_rresp <= rresp_d;
      s_rdata <= rdata_d;
    end
  end

endmodule

// >>> hdl/wer_wake_regs.sv
// wake enable registers three and four with wake status, wake line and interrupt
//
// Behaviour
// R1 - wake asserts when enable, status, global set
// R2 - disabled source still records status, no wake
// R3 - group three bits map port two pins
// R4 - group three bit 3 enables grouped smi
// R5 - group four bits map ports three/four/six
// R6 - enables survive all resets except standby
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module wer_wake_regs (
  input wire logic clock, // system clock, 40 MHz
  input wire logic resetn, // main synchronous reset, active low
  input wire logic standby_por_n, // standby power-on reset, synchronous, active low
  input wire logic gpio_port2_bit0, // wake source
  input wire logic gpio_port2_bit1, // wake source
  input wire logic gpio_port2_bit2, // wake source
  input wire logic grouped_smi_event, // grouped smi wake source
  input wire logic gpio_port2_bit4, // wake source
  input wire logic gpio_port2_bit5, // wake source
  input wire logic gpio_port2_bit6, // wake source
  input wire logic gpio_port2_bit7, // wake source
  input wire logic gpio_port3_bit0, // wake source
  input wire logic gpio_port3_bit1, // wake source
  input wire logic gpio_port3_bit2, // wake source
  input wire logic gpio_port3_bit3, // wake source
  input wire logic gpio_port4_bit1, // wake source
  input wire logic gpio_port4_bit3, // wake source
  input wire logic gpio_port6_bit0, // wake source
  input wire logic gpio_port6_bit1, // wake source
  output logic wake_request_out_n, // system wake line, active low
  output logic irq, // level interrupt
  input wire logic [wer_pkg::WER_AXI_AW-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [wer_pkg::WER_AXI_DW-1:0] s_wdata, // write data
  input wire logic [wer_pkg::WER_STRB_W-1:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [wer_pkg::WER_AXI_AW-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [wer_pkg::WER_AXI_DW-1:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready // read data ready
);
  import wer_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic wr_en, wr_err, rd_en, rd_err;
  wer_idx_t wr_idx, rd_idx;
  logic [WER_AXI_DW-1:0] wr_data, rd_data;
  logic [WER_STRB_W-1:0] wr_strb;
  logic wr_lane0;

  wer_byte_t en3_q, en3_d, en4_q, en4_d;
  wer_byte_t src3, src4, sts3_q, sts4_q, clr3, clr4;
  wer_byte_t pend3, pend4;
  logic global_q, global_d;
  logic [WER_INT_W-1:0] int_sts_q, int_en_q, int_en_d, int_set, int_clr;
  logic wake_d, irq_d;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  wer_axil_slave u_bus (
    .clock(clock),
    .resetn(resetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_lane0 = wr_en && wr_strb[WER_LANE0];

  // ----------------------------------------------------------------
  // wake source mapping
  // ----------------------------------------------------------------
  assign src3 = {gpio_port2_bit7, gpio_port2_bit6, gpio_port2_bit5, gpio_port2_bit4, // R3
                 grouped_smi_event, // R4
                 gpio_port2_bit2, gpio_port2_bit1, gpio_port2_bit0}; // R3
  assign src4 = {gpio_port6_bit1, gpio_port6_bit0, gpio_port4_bit3, gpio_port4_bit1, // R5
                 gpio_port3_bit3, gpio_port3_bit2, gpio_port3_bit1, gpio_port3_bit0}; // R5

  // ----------------------------------------------------------------
  // wake status, recorded whatever the enables say
  // ----------------------------------------------------------------
  assign clr3 = (wr_lane0 && wr_idx == WER_IDX_STS3) ? wr_data[WER_REG_W-1:0] : WER_STS_RST;
  assign clr4 = (wr_lane0 && wr_idx == WER_IDX_STS4) ? wr_data[WER_REG_W-1:0] : WER_STS_RST;

  wer_sticky #(.W(WER_REG_W)) u_sts3 (
    .clock(clock),
    .resetn(resetn),
    .set(src3), // R2
    .clr(clr3),
    .q(sts3_q)
  );

  wer_sticky #(.W(WER_REG_W)) u_sts4 (
    .clock(clock),
    .resetn(resetn),
    .set(src4), // R2
    .clr(clr4),
    .q(sts4_q)
  );

  // ----------------------------------------------------------------
  // enable registers: standby domain, main reset leaves them alone
  // ----------------------------------------------------------------
  always_comb begin
    en3_d = en3_q;
    en4_d = en4_q;
    if (wr_lane0 && wr_idx == WER_IDX_EN3) begin
      en3_d = wr_data[WER_REG_W-1:0];
    end
    if (wr_lane0 && wr_idx == WER_IDX_EN4) begin
      en4_d = wr_data[WER_REG_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!standby_por_n) begin
      en3_q <= WER_EN_RST; // R6
      en4_q <= WER_EN_RST; // R6
    end else begin
      en3_q <= en3_d;
      en4_q <= en4_d;
    end
  end

  // ----------------------------------------------------------------
  // control, interrupt enable, wake line and interrupt output
  // ----------------------------------------------------------------
  assign pend3 = en3_q & sts3_q; // R1 R4
  assign pend4 = en4_q & sts4_q; // R1

  always_comb begin
    global_d = global_q;
    int_en_d = int_en_q;
    if (wr_lane0 && wr_idx == WER_IDX_CTRL) begin
      global_d = wr_data[WER_CTRL_GLOBAL_BIT];
    end
    if (wr_lane0 && wr_idx == WER_IDX_INT_EN) begin
      int_en_d = wr_data[WER_INT_W-1:0];
    end
    wake_d = !(global_q && (|pend3 || |pend4)); // R1 R2
    irq_d = |(int_sts_q & int_en_q);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      global_q <= WER_CTRL_RST;
      int_en_q <= WER_INT_RST;
      wake_request_out_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      global_q <= global_d;
      int_en_q <= int_en_d;
      wake_request_out_n <= wake_d;
      irq <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  always_comb begin
    int_set = '0;
    int_set[WER_INT_STS3] = |(src3 & ~sts3_q);
    int_set[WER_INT_STS4] = |(src4 & ~sts4_q);
    int_set[WER_INT_WAKE] = wake_request_out_n && !wake_d;
    int_clr = (wr_lane0 && wr_idx == WER_IDX_INT_CLR) ? wr_data[WER_INT_W-1:0] : WER_INT_RST;
  end

  wer_sticky #(.W(WER_INT_W)) u_int (
    .clock(clock),
    .resetn(resetn),
    .set(int_set),
    .clr(int_clr),
    .q(int_sts_q)
  );

  // ----------------------------------------------------------------
  // decode: write legality and read mux
  // ----------------------------------------------------------------
  always_comb begin
    wr_err = 1'b0;
    case (wr_idx)
      WER_IDX_EN3, WER_IDX_EN4, WER_IDX_STS3, WER_IDX_STS4,
      WER_IDX_CTRL, WER_IDX_INT_CLR, WER_IDX_INT_EN: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (rd_idx)
      WER_IDX_EN3: rd_data[WER_REG_W-1:0] = en3_q;
      WER_IDX_EN4: rd_data[WER_REG_W-1:0] = en4_q;
      WER_IDX_STS3: rd_data[WER_REG_W-1:0] = sts3_q;
      WER_IDX_STS4: rd_data[WER_REG_W-1:0] = sts4_q;
      WER_IDX_CTRL: rd_data[WER_CTRL_GLOBAL_BIT] = global_q;
      WER_IDX_INT_STS: rd_data[WER_INT_W-1:0] = int_sts_q;
      WER_IDX_INT_CLR: rd_data = '0;
      WER_IDX_INT_EN: rd_data[WER_INT_W-1:0] = int_en_q;
      default: rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_WAKE_DRIVE: assert property (@(posedge clock) disable iff (!resetn) // R1
    (global_q && (|pend3 || |pend4)) |=> !wake_request_out_n)
    else $error("wake line not driven for an enabled pending source");

  AST_WAKE_QUIET: assert property (@(posedge clock) disable iff (!resetn) // R2
    !(global_q && (|pend3 || |pend4)) |=> wake_request_out_n)
    else $error("wake line driven with no enabled pending source");

  AST_STATUS_RECORD: assert property (@(posedge clock) disable iff (!resetn) // R2
    (src3 & ~en3_q) != '0 |=> ((sts3_q & $past(src3) & ~$past(en3_q)) == ($past(src3) & ~$past(en3_q))))
    else $error("disabled source not recorded in status");

  AST_MAP_GROUP3: assert property (@(posedge clock) disable iff (!resetn) // R3
    (gpio_port2_bit0 && gpio_port2_bit4) |=> (sts3_q[0] && sts3_q[4]))
    else $error("group three pin mapping wrong");

  AST_SMI_BIT3: assert property (@(posedge clock) disable iff (!resetn) // R4
    (grouped_smi_event && !wr_en) |=> sts3_q[WER_EN3_SMI_BIT] ##1 (sts3_q[WER_EN3_SMI_BIT] || $past(wr_lane0)))
    else $error("grouped smi not recorded in bit 3");

  AST_MAP_GROUP4: assert property (@(posedge clock) disable iff (!resetn) // R5
    (gpio_port4_bit1 && gpio_port6_bit1) |=> (sts4_q[4] && sts4_q[7]))
    else $error("group four pin mapping wrong");

  AST_EN_KEEP: assert property (@(posedge clock) disable iff (!standby_por_n) // R6
    !resetn |=> (en3_q == $past(en3_q) && en4_q == $past(en4_q)))
    else $error("enables disturbed by main reset");

  AST_EN_CLEAR: assert property (@(posedge clock) // R6
    !standby_por_n |=> (en3_q == WER_EN_RST && en4_q == WER_EN_RST))
    else $error("enables not cleared by standby reset");

  AST_STATUS_RECORD4: assert property (@(posedge clock) disable iff (!resetn) // R2
    (src4 & ~en4_q) != '0 |=> ((sts4_q & $past(src4) & ~$past(en4_q)) == ($past(src4) & ~$past(en4_q))))
    else $error("disabled group four source not recorded");

  AST_STS_HOLD: assert property (@(posedge clock) disable iff (!resetn) // R2
    !(wr_lane0 && wr_idx == WER_IDX_STS3) |=> ((sts3_q & $past(sts3_q)) == $past(sts3_q)))
    else $error("status three lost a bit without a clear");

  AST_MAP_GROUP3_HI: assert property (@(posedge clock) disable iff (!resetn) // R3
    (gpio_port2_bit2 && gpio_port2_bit7) |=> (sts3_q[2] && sts3_q[7]))
    else $error("group three upper pin mapping wrong");

  AST_MAP_GROUP4_LO: assert property (@(posedge clock) disable iff (!resetn) // R5
    (gpio_port3_bit0 && gpio_port6_bit0) |=> (sts4_q[0] && sts4_q[6]))
    else $error("group four lower pin mapping wrong");

  AST_SMI_WAKE: assert property (@(posedge clock) disable iff (!resetn || !standby_por_n) // R4
    (grouped_smi_event && en3_q[WER_EN3_SMI_BIT] && global_q && !wr_en) |=> ##1 !wake_request_out_n)
    else $error("enabled grouped smi did not drive the wake line");

  AST_INT_WAKE: assert property (@(posedge clock) disable iff (!resetn)
    (wake_request_out_n && !wake_d) |=> int_sts_q[WER_INT_WAKE])
    else $error("wake assertion not latched in interrupt status");

  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (!resetn)
    ((int_sts_q & int_en_q) != '0) |=> irq)
    else $error("interrupt low with an enabled status bit");

endmodule

// >>> testbench/wer_host_model.sv
// host side of the wake line: counts wake assertions seen on the active-low line
`timescale 1ns/1ps
module wer_host_model (
  input wire logic clock, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic wake_request_out_n, // wake line from the device
  output int wake_events // falling edges seen since reset
);
  logic line_q;

  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      line_q <= 1'b1;
      wake_events <= 0;
    end else begin
      line_q <= wake_request_out_n;
      if (line_q && !wake_request_out_n) begin
        wake_events <= wake_events + 1;
      end
    end
  end
endmodule

// >>> testbench/tb_wake_enable_regs_3_4.sv
// self-checking testbench of the wake enable register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_wake_enable_regs_3_4;
  import wer_pkg::*;
  localparam logic [7:0] A_EN3 = {WER_IDX_EN3, 2'b00};
  localparam logic [7:0] A_EN4 = {WER_IDX_EN4, 2'b00};
  localparam logic [7:0] A_STS3 = {WER_IDX_STS3, 2'b00};
  localparam logic [7:0] A_STS4 = {WER_IDX_STS4, 2'b00};
  localparam logic [7:0] A_CTRL = {WER_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_ICLR = {WER_IDX_INT_CLR, 2'b00};
  localparam logic [7:0] A_IEN = {WER_IDX_INT_EN, 2'b00};
  logic clock, resetn, standby_por_n, wake_request_out_n, irq;
  logic [15:0] src;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int err_count, comparisons, seed, wake_events;

  wer_wake_regs dut (
    .clock(clock), .resetn(resetn), .standby_por_n(standby_por_n),
    .gpio_port2_bit0(src[0]), .gpio_port2_bit1(src[1]), .gpio_port2_bit2(src[2]), .grouped_smi_event(src[3]),
    .gpio_port2_bit4(src[4]), .gpio_port2_bit5(src[5]), .gpio_port2_bit6(src[6]), .gpio_port2_bit7(src[7]),
    .gpio_port3_bit0(src[8]), .gpio_port3_bit1(src[9]), .gpio_port3_bit2(src[10]), .gpio_port3_bit3(src[11]),
    .gpio_port4_bit1(src[12]), .gpio_port4_bit3(src[13]), .gpio_port6_bit0(src[14]), .gpio_port6_bit1(src[15]),
    .wake_request_out_n(wake_request_out_n), .irq(irq),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready)
  );

  wer_host_model host (.clock(clock), .resetn(resetn), .wake_request_out_n(wake_request_out_n),
    .wake_events(wake_events));

  // ----------------------------------------------------------------
  // clock, bus tasks and verdict
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge clock);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1;
      end
    end
    while (bvalid !== 1'b1) @(posedge clock);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er, input string nm);
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    rready <= 1'b0;
    `CHK(nm, ex, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // one-cycle source pulse, then room for status, wake line and interrupt to settle
  task automatic pulse(input logic [15:0] m);
    @(posedge clock);
    src <= m;
    @(posedge clock);
    src <= 16'h0000;
    repeat (5) @(posedge clock);
  endtask

  task automatic clear_status;
    wr(A_STS3, 32'h0000_00ff, WER_RESP_OKAY);
    wr(A_STS4, 32'h0000_00ff, WER_RESP_OKAY);
    wr(A_ICLR, 32'h0000_0007, WER_RESP_OKAY);
    repeat (3) @(posedge clock);
  endtask

  function automatic logic exp_wake_n(input logic [15:0] en, input logic [15:0] sts, input logic glob);
    return !(glob && |(en & sts));
  endfunction

  task complete_run;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] m, en, s;
    seed = 28414;
    err_count = 0;
    comparisons = 0;
    resetn = 1'b0; standby_por_n = 1'b0; src = 16'h0000;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0000_0000; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    standby_por_n <= 1'b1;
    @(posedge clock);
    rd(A_EN3, 32'h0000_0000, WER_RESP_OKAY, "en3 reset");
    rd(A_EN4, 32'h0000_0000, WER_RESP_OKAY, "en4 reset");
    wr(A_CTRL, 32'h0000_0001, WER_RESP_OKAY);
    wr(A_IEN, 32'h0000_0004, WER_RESP_OKAY);
    // each source alone: first with its own enable off, then on
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      wr(A_EN3, {24'h0, ~m[7:0]}, WER_RESP_OKAY);
      wr(A_EN4, {24'h0, ~m[15:8]}, WER_RESP_OKAY);
      pulse(m);
      `CHK("wake line disabled", 1'b1, wake_request_out_n)
      rd(A_STS3, {24'h0, m[7:0]}, WER_RESP_OKAY, "status three");
      rd(A_STS4, {24'h0, m[15:8]}, WER_RESP_OKAY, "status four");
      clear_status;
      wr(A_EN3, {24'h0, m[7:0]}, WER_RESP_OKAY);
      wr(A_EN4, {24'h0, m[15:8]}, WER_RESP_OKAY);
      pulse(m);
      `CHK("wake line enabled", 1'b0, wake_request_out_n)
      `CHK("host wake count", i + 1, wake_events)
      `CHK("irq on wake", 1'b1, irq)
      rd({WER_IDX_INT_STS, 2'b00}, {29'h0, 1'b1, |m[15:8], |m[7:0]}, WER_RESP_OKAY, "int status");
      if (i == 0) begin
        wr(A_IEN, 32'h0000_0000, WER_RESP_OKAY);
        repeat (3) @(posedge clock);
        `CHK("irq masked", 1'b0, irq)
        wr(A_IEN, 32'h0000_0004, WER_RESP_OKAY);
        repeat (3) @(posedge clock);
        `CHK("irq unmasked", 1'b1, irq)
      end
      clear_status;
      `CHK("wake line released", 1'b1, wake_request_out_n)
      `CHK("irq cleared", 1'b0, irq)
    end
    // global enable gates every source
    wr(A_EN3, 32'h0000_00ff, WER_RESP_OKAY);
    wr(A_EN4, 32'h0000_00ff, WER_RESP_OKAY);
    wr(A_CTRL, 32'h0000_0000, WER_RESP_OKAY);
    pulse(16'hffff);
    `CHK("wake line global off", 1'b1, wake_request_out_n)
    wr(A_CTRL, 32'h0000_0001, WER_RESP_OKAY);
    repeat (3) @(posedge clock);
    `CHK("wake line global on", 1'b0, wake_request_out_n)
    clear_status;
    // random enable and source mixes
    for (int k = 0; k < 8; k++) begin
      en = 16'($random(seed));
      s = 16'($random(seed));
      wr(A_EN3, {24'h0, en[7:0]}, WER_RESP_OKAY);
      wr(A_EN4, {24'h0, en[15:8]}, WER_RESP_OKAY);
      pulse(s);
      `CHK("wake line random", exp_wake_n(en, s, 1'b1), wake_request_out_n)
      rd(A_STS3, {24'h0, s[7:0]}, WER_RESP_OKAY, "status three random");
      rd(A_STS4, {24'h0, s[15:8]}, WER_RESP_OKAY, "status four random");
      clear_status;
      `CHK("wake line random clear", 1'b1, wake_request_out_n)
    end
    // unmapped index
    wr(8'hfc, 32'h0000_00ff, WER_RESP_SLVERR);
    rd(8'hfc, 32'h0000_0000, WER_RESP_SLVERR, "unmapped read");
    // enables survive main reset, cleared only by standby reset
    wr(A_EN3, 32'h0000_00a5, WER_RESP_OKAY);
    wr(A_EN4, 32'h0000_003c, WER_RESP_OKAY);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(A_EN3, 32'h0000_00a5, WER_RESP_OKAY, "en3 kept");
    rd(A_EN4, 32'h0000_003c, WER_RESP_OKAY, "en4 kept");
    rd(A_CTRL, 32'h0000_0000, WER_RESP_OKAY, "ctrl reset");
    @(posedge clock);
    resetn <= 1'b0;
    standby_por_n <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    standby_por_n <= 1'b1;
    @(posedge clock);
    rd(A_EN3, 32'h0000_0000, WER_RESP_OKAY, "en3 standby");
    rd(A_EN4, 32'h0000_0000, WER_RESP_OKAY, "en4 standby");
    complete_run;
  end
endmodule
